// file: eid_consts.svh
`ifndef EID_CONSTS_SVH
`define EID_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define EID_OFS_ENABLE     8'h00
`define EID_OFS_SENSE      8'h04
`define EID_OFS_STATUS     8'h08
`define EID_OFS_PRIORITY   8'h0c
`define EID_OFS_EVT_STATUS 8'h10
`define EID_OFS_EVT_MASK   8'h14

// Reset values
`define EID_RST_ENABLE   8'h00
`define EID_RST_SENSE    16'h0000
`define EID_RST_STATUS   8'h00
`define EID_RST_PRIORITY 32'h77777777
`define EID_RST_EVT      8'h00

// Field layout
`define EID_LINES        8
`define EID_PRIO_STRIDE  4
`define EID_PRIO_W       3

// Bus answers
`define EID_RESP_OKAY    2'b00
`define EID_RESP_SLVERR  2'b10

`endif

// file: eid_pkg.sv
package eid_pkg;
	// Activation strobe naming one line, from same-clock logic
	typedef struct packed {
		logic       valid;
		logic [2:0] line;
	} eid_ack_t;

	// Sense field encoding, high bit then low bit
	typedef enum logic [1:0] {
		EID_SENSE_LOW,
		EID_SENSE_FALL,
		EID_SENSE_RISE,
		EID_SENSE_BOTH
	} eid_sense_t;

	// Register select after address decode
	typedef enum logic [2:0] {
		EID_SEL_ENABLE,
		EID_SEL_SENSE,
		EID_SEL_STATUS,
		EID_SEL_PRIORITY,
		EID_SEL_EVT_STATUS,
		EID_SEL_EVT_MASK,
		EID_SEL_NONE
	} eid_sel_t;
endpackage

// file: eid_irq_detect.sv
// How it works
// [RULE_01] Enable bit 0 blocks a line's request, 1 lets it through.
// [RULE_02] Enable register clears to zero on reset and hardware standby.
// [RULE_03] Two-bit sense field: 00 low level, 01 fall, 10 rise, 11 both.
// [RULE_04] All sixteen sense bits clear on reset and standby, giving low-level sense.
// [RULE_05] Request status register clears to zero on reset and standby.
// [RULE_06] Software writes only clear flags: 0 clears, 1 leaves unchanged.
// [RULE_07] Software clear needs a prior read of the flag as 1, then a 0 write.
// [RULE_08] Low-level mode: exception handling with the pin high clears the flag.
// [RULE_09] Edge modes: exception handling for that line clears its flag.
// [RULE_10] Transfer controller activation clears the flag when disable-select is 0.
// [RULE_11] Low-level mode sets the flag whenever the pin is low.
// [RULE_12] Falling-edge mode sets the flag on each high-to-low change.
// [RULE_13] Rising-edge mode sets the flag on each low-to-high change.
// [RULE_14] Both-edge mode sets the flag on every change of the pin.
// [RULE_15] Each line has a three-bit priority, 0 lowest, 7 highest, used in arbitration.
// [RULE_16] A line requests arbitration only while its flag and enable are both 1.
`include "eid_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module eid_irq_detect (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              hw_standby,
	input  wire logic [7:0]        external_request_pins_n,
	input  wire eid_pkg::eid_ack_t exc_ack,
	input  wire eid_pkg::eid_ack_t dtc_act,
	input  wire logic              transfer_disable_select,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [7:0]             line_request,
	output logic [2:0]             top_level,
	output logic                   irq
);
	import eid_pkg::*;

	// Address decode shared by both channels
	function automatic eid_sel_t decode(input logic [7:0] addr);
		unique case (addr)
			`EID_OFS_ENABLE:     decode = EID_SEL_ENABLE;
			`EID_OFS_SENSE:      decode = EID_SEL_SENSE;
			`EID_OFS_STATUS:     decode = EID_SEL_STATUS;
			`EID_OFS_PRIORITY:   decode = EID_SEL_PRIORITY;
			`EID_OFS_EVT_STATUS: decode = EID_SEL_EVT_STATUS;
			`EID_OFS_EVT_MASK:   decode = EID_SEL_EVT_MASK;
			default:             decode = EID_SEL_NONE;
		endcase
	endfunction

	// Byte-lane merge for a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		merge = res;
	endfunction

	// Sense mode of one line
	function automatic eid_sense_t line_mode(input logic [15:0] sense, input int n);
		line_mode = eid_sense_t'(sense[2*n +: 2]);
	endfunction

	// Pin and standby synchronisers
	logic [7:0] pin_s1_reg;
	logic [7:0] pin_s2_reg;
	logic [7:0] pin_s3_reg;
	logic       stby_s1_reg;
	logic       stby_s2_reg;

	// Pins are asynchronous; s3 only serves edge detection
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_s1_reg  <= 8'hff;
			pin_s2_reg  <= 8'hff;
			pin_s3_reg  <= 8'hff;
			stby_s1_reg <= 1'b0;
			stby_s2_reg <= 1'b0;
		end else begin
			pin_s1_reg  <= external_request_pins_n;
			pin_s2_reg  <= pin_s1_reg;
			pin_s3_reg  <= pin_s2_reg;
			stby_s1_reg <= hw_standby;
			stby_s2_reg <= stby_s1_reg;
		end
	end

	// Register state
	logic [7:0]  enable_reg;
	logic [7:0]  enable_next;
	logic [15:0] sense_reg;
	logic [15:0] sense_next;
	logic [7:0]  status_reg;
	logic [7:0]  status_next;
	logic [7:0]  seen_reg;
	logic [7:0]  seen_next;
	logic [31:0] prio_reg;
	logic [31:0] prio_next;
	logic [7:0]  evt_reg;
	logic [7:0]  evt_next;
	logic [7:0]  mask_reg;
	logic [7:0]  mask_next;
	logic [7:0]  req_reg;
	logic [7:0]  req_next;
	logic [2:0]  top_reg;
	logic [2:0]  top_next;
	logic        irq_reg;
	logic        irq_next;

	// Bus state
	logic        awrdy_reg;
	logic        awrdy_next;
	logic        bvalid_reg;
	logic        bvalid_next;
	logic [1:0]  bresp_reg;
	logic [1:0]  bresp_next;
	logic        arrdy_reg;
	logic        arrdy_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [1:0]  rresp_reg;
	logic [1:0]  rresp_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// Detection and clear terms per line
	logic [7:0]  set_vec;
	logic [7:0]  hw_clr;
	logic [7:0]  sw_clr;
	logic        wr_fire;
	logic        rd_fire;
	eid_sel_t    wsel;
	eid_sel_t    rsel;

	assign wr_fire = awrdy_reg && s_axi_awvalid && s_axi_wvalid;
	assign rd_fire = arrdy_reg && s_axi_arvalid;
	assign wsel    = decode(s_axi_awaddr);
	assign rsel    = decode(s_axi_araddr);

	// Detection per sense mode and hardware clear causes
	always_comb begin
		for (int n = 0; n < `EID_LINES; n++) begin
			unique case (line_mode(sense_reg, n)) // RULE_03
				EID_SENSE_LOW:  set_vec[n] = !pin_s2_reg[n]; // RULE_11
				EID_SENSE_FALL: set_vec[n] = pin_s3_reg[n] && !pin_s2_reg[n]; // RULE_12
				EID_SENSE_RISE: set_vec[n] = !pin_s3_reg[n] && pin_s2_reg[n]; // RULE_13
				EID_SENSE_BOTH: set_vec[n] = pin_s3_reg[n] != pin_s2_reg[n]; // RULE_14
			endcase
			hw_clr[n] = 1'b0;
			if (exc_ack.valid && exc_ack.line == 3'(n)) begin
				if (line_mode(sense_reg, n) == EID_SENSE_LOW) begin
					hw_clr[n] = pin_s2_reg[n]; // RULE_08
				end else begin
					hw_clr[n] = 1'b1; // RULE_09
				end
			end
			if (dtc_act.valid && dtc_act.line == 3'(n) && !transfer_disable_select) begin
				hw_clr[n] = 1'b1; // RULE_10
			end
			// Only flags read as 1 and then written 0 are cleared
			sw_clr[n] = wr_fire && wsel == EID_SEL_STATUS && s_axi_wstrb[0]
				&& !s_axi_wdata[n] && seen_reg[n]; // RULE_06 RULE_07
		end
	end

	// Register file next values; a new detection beats any clear except standby
	always_comb begin
		logic [31:0] wv;
		logic [2:0]  best;
		wv          = 32'h00000000;
		best        = 3'h0;
		enable_next = enable_reg;
		sense_next  = sense_reg;
		prio_next   = prio_reg;
		mask_next   = mask_reg;
		status_next = (status_reg & ~(hw_clr | sw_clr)) | set_vec;
		seen_next   = seen_reg & ~hw_clr;
		evt_next    = evt_reg | set_vec;
		if (rd_fire && rsel == EID_SEL_STATUS) begin
			seen_next = seen_next | status_reg; // RULE_07
		end
		if (wr_fire) begin
			unique case (wsel)
				EID_SEL_ENABLE: begin
					wv          = merge({24'h000000, enable_reg}, s_axi_wdata, s_axi_wstrb);
					enable_next = wv[7:0];
				end
				EID_SEL_SENSE: begin
					wv         = merge({16'h0000, sense_reg}, s_axi_wdata, s_axi_wstrb);
					sense_next = wv[15:0];
				end
				EID_SEL_STATUS: begin
					seen_next = 8'h00; // A write consumes the earlier read
				end
				EID_SEL_PRIORITY: begin
					wv        = merge(prio_reg, s_axi_wdata, s_axi_wstrb);
					prio_next = wv & `EID_RST_PRIORITY; // Spare bits stay zero
				end
				EID_SEL_EVT_STATUS: begin
					if (s_axi_wstrb[0]) begin
						evt_next = (evt_reg & ~s_axi_wdata[7:0]) | set_vec;
					end
				end
				EID_SEL_EVT_MASK: begin
					wv        = merge({24'h000000, mask_reg}, s_axi_wdata, s_axi_wstrb);
					mask_next = wv[7:0];
				end
				EID_SEL_NONE: wv = 32'h00000000;
			endcase
		end
		if (stby_s2_reg) begin
			enable_next = `EID_RST_ENABLE; // RULE_02
			sense_next  = `EID_RST_SENSE; // RULE_04
			status_next = `EID_RST_STATUS; // RULE_05
			prio_next   = `EID_RST_PRIORITY;
			seen_next   = 8'h00;
		end
		// Request only while flag and enable are both 1; ranked by level
		req_next = status_reg & enable_reg; // RULE_01 RULE_16
		for (int n = 0; n < `EID_LINES; n++) begin
			if (req_next[n] && prio_reg[`EID_PRIO_STRIDE*n +: `EID_PRIO_W] > best) begin
				best = prio_reg[`EID_PRIO_STRIDE*n +: `EID_PRIO_W]; // RULE_15
			end
		end
		top_next = best;
		irq_next = |(evt_reg & mask_reg);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			enable_reg <= `EID_RST_ENABLE; // RULE_02
			sense_reg  <= `EID_RST_SENSE; // RULE_04
			status_reg <= `EID_RST_STATUS; // RULE_05
			seen_reg   <= 8'h00;
			prio_reg   <= `EID_RST_PRIORITY;
			evt_reg    <= `EID_RST_EVT;
			mask_reg   <= `EID_RST_EVT;
			req_reg    <= 8'h00;
			top_reg    <= 3'h0;
			irq_reg    <= 1'b0;
		end else begin
			enable_reg <= enable_next;
			sense_reg  <= sense_next;
			status_reg <= status_next;
			seen_reg   <= seen_next;
			prio_reg   <= prio_next;
			evt_reg    <= evt_next;
			mask_reg   <= mask_next;
			req_reg    <= req_next;
			top_reg    <= top_next;
			irq_reg    <= irq_next;
		end
	end

	// AXI4-Lite handshakes; one transfer per channel pair at a time
	always_comb begin
		awrdy_next  = 1'b0;
		bvalid_next = bvalid_reg;
		bresp_next  = bresp_reg;
		arrdy_next  = 1'b0;
		rvalid_next = rvalid_reg;
		rresp_next  = rresp_reg;
		rdata_next  = rdata_reg;
		if (s_axi_awvalid && s_axi_wvalid && !awrdy_reg && !bvalid_reg) begin
			awrdy_next = 1'b1; // Address and data taken together
		end
		if (wr_fire) begin
			bvalid_next = 1'b1;
			bresp_next  = (wsel == EID_SEL_NONE) ? `EID_RESP_SLVERR : `EID_RESP_OKAY;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && !arrdy_reg && !rvalid_reg) begin
			arrdy_next = 1'b1;
		end
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next  = `EID_RESP_OKAY;
			unique case (rsel)
				EID_SEL_ENABLE:     rdata_next = {24'h000000, enable_reg};
				EID_SEL_SENSE:      rdata_next = {16'h0000, sense_reg};
				EID_SEL_STATUS:     rdata_next = {24'h000000, status_reg};
				EID_SEL_PRIORITY:   rdata_next = prio_reg;
				EID_SEL_EVT_STATUS: rdata_next = {24'h000000, evt_reg};
				EID_SEL_EVT_MASK:   rdata_next = {24'h000000, mask_reg};
				EID_SEL_NONE: begin
					rdata_next = 32'h00000000;
					rresp_next = `EID_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			awrdy_reg  <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= `EID_RESP_OKAY;
			arrdy_reg  <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg  <= `EID_RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end else begin
			awrdy_reg  <= awrdy_next;
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
			arrdy_reg  <= arrdy_next;
			rvalid_reg <= rvalid_next;
			rresp_reg  <= rresp_next;
			rdata_reg  <= rdata_next;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awrdy_reg;
	assign s_axi_wready  = awrdy_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arrdy_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign line_request  = req_reg;
	assign top_level     = top_reg;
	assign irq           = irq_reg;
	// Checks on the driven state
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_standby;
		stby_s2_reg;
	endsequence
	sequence s_status_write_zero;
		wr_fire && wsel == EID_SEL_STATUS && s_axi_wstrb[0] && s_axi_wdata[7:0] == 8'h00;
	endsequence
	a_standby_clears: assert property (s_standby |=> enable_reg == 8'h00 && sense_reg == 16'h0000
		&& status_reg == 8'h00) // RULE_02 RULE_04 RULE_05
		else $error("standby did not clear the line registers");
	a_reset_values: assert property ($rose(nrst) |-> enable_reg == 8'h00
		&& sense_reg == 16'h0000 && status_reg == 8'h00) // RULE_02
		else $error("reset values wrong");
	a_request_gate: assert property (##1 // RULE_16
		req_reg == ($past(status_reg) & $past(enable_reg)))
		else $error("line request not flag and enable");
	a_enable_blocks: assert property ((enable_reg == 8'h00) [*2] |-> req_reg == 8'h00) // RULE_01
		else $error("disabled line raised a request");
	a_flag_set_wins: assert property (set_vec != 8'h00 && !stby_s2_reg
		|=> (status_reg & $past(set_vec)) == $past(set_vec)) // RULE_11
		else $error("detection lost");
	a_clear_has_cause: assert property (##1 !$past(stby_s2_reg) |-> // RULE_06
		(($past(status_reg) & ~status_reg) & ~($past(hw_clr) | $past(sw_clr))) == 8'h00)
		else $error("flag fell without a cause");
	a_unread_survives: assert property (s_status_write_zero and (seen_reg == 8'h00)
		and (hw_clr == 8'h00) and !stby_s2_reg
		|=> (status_reg & $past(status_reg)) == $past(status_reg)) // RULE_07
		else $error("zero write without read cleared a flag");
	a_rise_detect: assert property (line_mode(sense_reg, 0) == EID_SENSE_RISE
		&& !pin_s3_reg[0] && pin_s2_reg[0] && !stby_s2_reg |=> status_reg[0]) // RULE_13
		else $error("rising edge missed on line 0");
	a_fall_detect: assert property (line_mode(sense_reg, 0) == EID_SENSE_FALL
		&& pin_s3_reg[0] && !pin_s2_reg[0] && !stby_s2_reg |=> status_reg[0]) // RULE_12
		else $error("falling edge missed on line 0");
	a_edge_ack_clear: assert property (exc_ack.valid && exc_ack.line == 3'h0
		&& line_mode(sense_reg, 0) != EID_SENSE_LOW && !set_vec[0] |=> !status_reg[0]) // RULE_09
		else $error("exception handling left edge flag set");
	a_dtc_clear: assert property (dtc_act.valid && !transfer_disable_select // RULE_10
		&& !set_vec[dtc_act.line] |=> !status_reg[$past(dtc_act.line)])
		else $error("transfer activation left flag set");
	a_write_answer: assert property (wr_fire |=> bvalid_reg && !awrdy_reg)
		else $error("write answer missing");
	a_write_release: assert property (bvalid_reg && s_axi_bready |=> !bvalid_reg)
		else $error("write answer kept after it was taken");
	a_read_answer: assert property (rd_fire |=> rvalid_reg && !arrdy_reg)
		else $error("read answer missing");
	a_irq_level: assert property (##1 irq_reg == |($past(evt_reg) & $past(mask_reg)))
		else $error("interrupt output wrong");
endmodule
`default_nettype wire

// file: eid_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side devices on the request pins, pulled up and idle high.
// The pins carry a steady level, so a change is held until the next one.
module eid_pin_model (
	input  wire logic clk,
	output logic [7:0] pins_n
);
	initial pins_n = 8'hff;

	// Each change lands just after a rising edge
	task automatic drive(input int ln, input logic v);
		@(posedge clk);
		pins_n[ln] <= v;
	endtask
endmodule

`default_nettype wire

// file: tb_external_irq_detect_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "eid_consts.svh"

module tb_external_irq_detect_flags;
	import eid_pkg::*;
	logic        clk, nrst, hw_standby, tds;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0]  awaddr, araddr, pins_n, line_request;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [2:0]  top_level;
	eid_ack_t    exc_ack, dtc_act;
	int          err_total, samples_checked, seed, l, p, m;
	// Reference model, one bit per line, two per line for the sense field
	int          m_en, m_sense, m_stat, m_evt, m_mask, m_seen, m_pin;

	eid_pin_model pm_i (.clk(clk), .pins_n(pins_n));

	eid_irq_detect eid_irq_detect_i (
		.clk(clk), .nrst(nrst), .hw_standby(hw_standby),
		.external_request_pins_n(pins_n), .exc_ack(exc_ack), .dtc_act(dtc_act),
		.transfer_disable_select(tds), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.line_request(line_request), .top_level(top_level), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("compares=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Address and data offered together; the slave takes both on one edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(posedge clk); while (!awready);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		chk(bresp, a > 8'h14 ? `EID_RESP_SLVERR : `EID_RESP_OKAY);
		case (a)
			`EID_OFS_ENABLE: m_en = v[7:0];
			`EID_OFS_SENSE: m_sense = v[15:0];
			`EID_OFS_STATUS: begin
				// Lane 0 off leaves the flags but still forgets the read
				if (wstrb[0]) m_stat &= ~(m_seen & ~v[7:0]);
				m_seen = 0;
			end
			`EID_OFS_EVT_STATUS: m_evt &= ~v[7:0];
			`EID_OFS_EVT_MASK: m_mask = v[7:0];
			default: ;
		endcase
	endtask

	task automatic rchk(input logic [7:0] a, input int exp);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		// Flags read as one become clearable by the next zero write
		if (a == `EID_OFS_STATUS) m_seen = exp;
		chk(rdata, exp);
		chk(rresp, a > 8'h14 ? `EID_RESP_SLVERR : `EID_RESP_OKAY);
	endtask

	// Detection judged from old and new pin level; six cycles covers the sync lag
	task automatic pin(input int ln, input logic v);
		logic o;
		int   md;
		o  = m_pin[ln];
		md = (m_sense >> (2 * ln)) & 3;
		pm_i.drive(ln, v);
		if ((md == 0 && !v) || (md == 1 && o && !v) || (md == 2 && !o && v) ||
			(md == 3 && o != v)) begin
			m_stat |= 1 << ln;
			m_evt  |= 1 << ln;
		end
		m_pin[ln] = v;
		repeat (6) @(posedge clk);
	endtask

	// One-cycle activation; a low-level line with its pin low sets again at once
	task automatic ack(input logic dt, input int ln, input logic ds);
		@(posedge clk);
		if (dt) begin
			dtc_act <= '{1'b1, ln[2:0]};
		end else begin
			exc_ack <= '{1'b1, ln[2:0]};
		end
		tds <= ds;
		@(posedge clk);
		dtc_act.valid <= 1'b0;
		exc_ack.valid <= 1'b0;
		if (!(dt && ds) && !(((m_sense >> (2 * ln)) & 3) == 0 && !m_pin[ln])) begin
			m_stat &= ~(1 << ln);
			m_seen &= ~(1 << ln);
		end
		repeat (2) @(posedge clk);
	endtask

	// Hang guard, far beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("watchdog expired");
		give_verdict;
	end

	initial begin
		{nrst, hw_standby, tds, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb   = 4'hf;
		exc_ack = '0;
		dtc_act = '0;
		{err_total, samples_checked, m_en, m_sense, m_stat, m_evt, m_mask, m_seen} = '0;
		m_pin = 8'hff;
		seed  = 82;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rchk(`EID_OFS_ENABLE, 0);
		rchk(`EID_OFS_SENSE, 0);
		rchk(`EID_OFS_STATUS, 0);
		rchk(`EID_OFS_PRIORITY, 32'h77777777);
		rchk(8'h18, 0);
		wr(8'h1c, 32'hffffffff);
		$display("test reset values done");
		// Every sense code, both pin directions; falling and rising codes on line 0,
		// where the design's edge and acknowledge checks look
		for (m = 0; m < 4; m++) begin
			l = (m == 1 || m == 2) ? 0 : $random(seed) & 7;
			wr(`EID_OFS_SENSE, m << (2 * l));
			pin(l, 1'b0);
			rchk(`EID_OFS_STATUS, m_stat);
			ack(1'b0, l, 1'b0);
			pin(l, 1'b1);
			rchk(`EID_OFS_STATUS, m_stat);
			ack(1'b0, l, 1'b0);
			rchk(`EID_OFS_STATUS, m_stat);
		end
		$display("test sense modes done");
		// Zero write before any read of one, then a one write, a zero write with lane 0 off, then the true clear
		pin(l, 1'b0);
		wr(`EID_OFS_STATUS, 0);
		rchk(`EID_OFS_STATUS, m_stat);
		wr(`EID_OFS_STATUS, 32'hff);
		rchk(`EID_OFS_STATUS, m_stat);
		wstrb <= 4'he;
		wr(`EID_OFS_STATUS, 0);
		wstrb <= 4'hf;
		rchk(`EID_OFS_STATUS, m_stat);
		wr(`EID_OFS_STATUS, 0);
		rchk(`EID_OFS_STATUS, m_stat);
		$display("test software clear done");
		pin(l, 1'b1);
		ack(1'b1, l, 1'b1);
		rchk(`EID_OFS_STATUS, m_stat);
		ack(1'b1, l, 1'b0);
		rchk(`EID_OFS_STATUS, m_stat);
		$display("test transfer clear done");
		// Enable gating, priority and the event interrupt, masked once
		for (m = 0; m < 3; m++) begin
			l = $random(seed) & 7;
			p = $random(seed) & 7;
			wr(`EID_OFS_SENSE, 3 << (2 * l));
			wr(`EID_OFS_ENABLE, $random(seed));
			wr(`EID_OFS_PRIORITY, p << (4 * l));
			wr(`EID_OFS_EVT_MASK, m == 1 ? 0 : 32'hff);
			pin(l, 1'b0);
			rchk(`EID_OFS_ENABLE, m_en);
			chk(line_request, m_stat & m_en);
			chk(top_level, m_en[l] ? p : 0);
			chk(irq, (m_evt & m_mask) != 0);
			wr(`EID_OFS_EVT_STATUS, 32'hff);
			repeat (2) @(posedge clk);
			chk(irq, 1'b0);
			ack(1'b0, l, 1'b0);
			pin(l, 1'b1);
			ack(1'b0, l, 1'b0);
		end
		$display("test request path done");
		// Standby with live state; pins left high so low-level sense stays quiet
		wr(`EID_OFS_ENABLE, 32'hff);
		pin(l, 1'b0);
		pin(l, 1'b1);
		hw_standby <= 1'b1;
		repeat (6) @(posedge clk);
		hw_standby <= 1'b0;
		repeat (4) @(posedge clk);
		rchk(`EID_OFS_ENABLE, 0);
		rchk(`EID_OFS_SENSE, 0);
		rchk(`EID_OFS_STATUS, 0);
		rchk(`EID_OFS_PRIORITY, 32'h77777777);
		$display("test standby done");
		give_verdict;
	end
endmodule

`default_nettype wire
